// *** inc/usc_defines.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the serial port
 * status and control block. Assumes inclusion by bare name from the include path.
 */
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH

// register offsets on the plain register port
`define USC_ADDR_W        4
`define USC_OFS_STA       4'h0
`define USC_OFS_MODE      4'h1
`define USC_OFS_TXD       4'h2
`define USC_OFS_RXD       4'h3

// status and control field positions
`define USC_STA_TXM1      15
`define USC_STA_INV       14
`define USC_STA_TXM0      13
`define USC_STA_BRK       11
`define USC_STA_TXEN      10
`define USC_STA_TXBF      9
`define USC_STA_DONE      8
`define USC_STA_RXM_HI    7
`define USC_STA_RXM_LO    6
`define USC_STA_ADDR_DETECT_EN     5

// mode register field positions
`define USC_MODE_INFRARED_ENCODER_EN     12
`define USC_MODE_PDS_HI   2
`define USC_MODE_PDS_LO   1

`define USC_STA_RESET     16'h0000
`define USC_MODE_RESET    16'h0000

// buffers
`define USC_FIFO_DEPTH    4
`define USC_DATA_W        9

// timing: clock cycles per oversample tick, ticks per bit
`define USC_CLK_MHZ       125
`define USC_BAUD_KHZ      7812
`define USC_TICK_CYC      (((`USC_CLK_MHZ * 1000) / (`USC_BAUD_KHZ * 16)) < 1 ? 1 : \
                           ((`USC_CLK_MHZ * 1000) / (`USC_BAUD_KHZ * 16)))
`define USC_OVS_LAST      4'hF
`define USC_IR_PULSE      4'h3
`define USC_BRK_BITS      4'hE
`define USC_BITS_8N       4'hA
`define USC_BITS_LONG     4'hB
`define USC_RX_3Q         3'h3
`define USC_RX_FULL       3'h4

`endif

// *** inc/usc_fifo_if.sv ***
/*
 * Carrier between a buffer and its user: fill side, drain side, flush, level.
 * Assumes the user drives the fill and drain requests on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface usc_fifo_if #(
	parameter int W = 9,
	parameter int D = 4
);
	logic                   wr_valid;
	logic                   wr_ready;
	logic [W-1:0]           wr_data;
	logic                   rd_valid;
	logic                   rd_ready;
	logic [W-1:0]           rd_data;
	logic                   flush;
	logic [$clog2(D+1)-1:0] level;

	modport buffer (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data, level);
	modport user   (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data, level);
endinterface : usc_fifo_if

`default_nettype wire

// *** inc/usc_pkg.sv ***
/*
 * Types of the serial port status and control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package usc_pkg;

	typedef enum logic [1:0] {
		USC_TX_IDLE  = 2'b01,
		USC_TX_SHIFT = 2'b10
	} usc_tx_state_t;

	typedef enum logic [1:0] {
		USC_TXI_EACH     = 2'h0,
		USC_TXI_ALL_DONE = 2'h1,
		USC_TXI_EMPTIED  = 2'h2,
		USC_TXI_RSVD     = 2'h3
	} usc_tx_irq_mode_t;

	typedef enum logic [1:0] {
		USC_PDS_8N = 2'h0,
		USC_PDS_8E = 2'h1,
		USC_PDS_8O = 2'h2,
		USC_PDS_9N = 2'h3
	} usc_parity_data_sel_t;

endpackage : usc_pkg

// *** verification/tb.sv ***
/*
 * Self-checking bench for usc_top with a remote transceiver model.
 * Assumes the register layout and bit timing of the shared defines.
 */
`timescale 1ns/10ps
`default_nettype none
`include "usc_defines.svh"

module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        rx_char_valid;
	logic [8:0]  rx_char_data;
	logic        pin_out;
	logic        pin_oe;
	logic        tx_irq;
	logic        rx_irq;
	logic        got;
	logic [13:0] frame;
	logic [3:0]  nbits = 4'hA;
	logic [15:0] d;
	int          n_errors = 0;
	int          comparisons = 0;
	int          n_txi = 0;
	int          n_rxi = 0;
	int          t0;
	logic [1:0]  mtab [3] = '{2'b00, 2'b10, 2'b01};
	logic [15:0] etab [3] = '{16'h0003, 16'h0002, 16'h0001};

	usc_top i_usc_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid),
		.rx_char_data(rx_char_data), .serial_tx_pin_out(pin_out), .serial_tx_pin_oe(pin_oe),
		.tx_irq(tx_irq), .rx_irq(rx_irq));
	usc_remote_model i_usc_remote_model (.clk(clk), .line(pin_out), .en(pin_oe), .nbits(nbits),
		.got(got), .frame(frame), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data));

	initial begin
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		n_txi += int'(tx_irq === 1'b1);
		n_rxi += int'(rx_irq === 1'b1);
	end

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wait_frame;
		for (int i = 0; i < 400 && got !== 1'b1; i++) cyc(1);
		chk({15'h0000, got}, 16'h0001);
		cyc(1);
	endtask : wait_frame

	task automatic end_sim;
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		end_sim;
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(`USC_OFS_STA, d); chk(d, 16'h0100);
		rd(4'h7, d); chk(d, 16'h0000);
		$display("test reset done");
		// transmit modes; 11 is never written
		for (int m = 0; m < 3; m++) begin
			wr(`USC_OFS_STA, {mtab[m][1], 1'b0, mtab[m][0], 3'b001, 10'h000});
			t0 = n_txi;
			wr(`USC_OFS_TXD, 16'h0031);
			cyc(4);
			wr(`USC_OFS_TXD, 16'h0032);
			wr(`USC_OFS_TXD, 16'h00C3);
			wait_frame; wait_frame; wait_frame;
			cyc(24);
			chk(16'(n_txi - t0), etab[m]);
			chk({6'h00, frame[9:0]}, {6'h00, 1'b1, 8'hC3, 1'b0});
			wr(`USC_OFS_STA, 16'h0000);
		end
		$display("test tx irq done");
		wr(`USC_OFS_STA, 16'h0400);
		rd(`USC_OFS_STA, d); chk(d, 16'h0500);
		repeat (5) wr(`USC_OFS_TXD, 16'h00A5);
		rd(`USC_OFS_STA, d); chk(d, 16'h0600);
		wr(`USC_OFS_STA, 16'h0000);
		rd(`USC_OFS_STA, d); chk(d, 16'h0100);
		chk({15'h0000, pin_oe}, 16'h0000);
		wr(`USC_OFS_STA, 16'h0400);
		rd(`USC_OFS_STA, d); chk(d, 16'h0500);
		wr(`USC_OFS_STA, 16'h0000);
		$display("test full and abort done");
		nbits = 4'hE;
		wr(`USC_OFS_STA, 16'h0C00);
		wait_frame;
		chk({2'h0, frame}, 16'h2000);
		cyc(16);
		rd(`USC_OFS_STA, d); chk(d, 16'h0500);
		wr(`USC_OFS_STA, 16'h0000);
		nbits = 4'hB;
		wr(`USC_OFS_MODE, 16'h0006);
		wr(`USC_OFS_STA, 16'h0400);
		wr(`USC_OFS_TXD, 16'h01A5);
		wait_frame;
		chk({5'h00, frame[10:0]}, {5'h00, 1'b1, 9'h1A5, 1'b0});
		wr(`USC_OFS_STA, 16'h0000);
		$display("test break and nine bit done");
		wr(`USC_OFS_MODE, 16'h1000);
		for (int v = 0; v < 2; v++) begin
			wr(`USC_OFS_STA, {1'b0, v[0], 4'h1, 10'h000});
			cyc(4);
			chk({15'h0000, pin_out}, {15'h0000, v[0]});
		end
		wr(`USC_OFS_STA, 16'h0000);
		wr(`USC_OFS_MODE, 16'h0000);
		wr(`USC_OFS_STA, 16'h4400);
		cyc(4);
		chk({15'h0000, pin_out}, 16'h0001);
		wr(`USC_OFS_STA, 16'h0000);
		$display("test encoder idle done");
		for (int m = 0; m < 4; m++) begin
			wr(`USC_OFS_STA, {8'h00, m[1:0], 6'h00});
			t0 = n_rxi;
			for (int k = 0; k < 4; k++) i_usc_remote_model.send({5'h00, k[3:0]});
			cyc(2);
			chk(16'(n_rxi - t0), m < 2 ? 16'h0004 : 16'h0001);
			for (int k = 0; k < 4; k++) begin
				rd(`USC_OFS_RXD, d); chk(d, {12'h000, k[3:0]});
			end
		end
		wr(`USC_OFS_MODE, 16'h0006);
		wr(`USC_OFS_STA, 16'h0020);
		t0 = n_rxi;
		i_usc_remote_model.send(9'h055);
		i_usc_remote_model.send(9'h1AA);
		cyc(2);
		chk(16'(n_rxi - t0), 16'h0001);
		rd(`USC_OFS_RXD, d); chk(d, 16'h01AA);
		rd(`USC_OFS_RXD, d); chk(d, 16'h0000);
		wr(`USC_OFS_MODE, 16'h0000);
		i_usc_remote_model.send(9'h055);
		cyc(2);
		rd(`USC_OFS_RXD, d); chk(d, 16'h0055);
		$display("test receive done");
		end_sim;
	end
endmodule : tb

`default_nettype wire

// *** verification/usc_remote_model.sv ***
/*
 * Remote serial transceiver: decodes frames off the line, hands received chars in.
 * Assumes one bit lasts 16 clock cycles and nbits is set before a frame starts.
 */
`timescale 1ns/10ps
`default_nettype none

module usc_remote_model (
	input  wire logic       clk,
	input  wire logic       line,
	input  wire logic       en,
	input  wire logic [3:0] nbits,
	output var  logic       got,
	output var  logic [13:0] frame,
	output var  logic       rx_char_valid,
	output var  logic [8:0] rx_char_data
);
	logic       busy;
	logic [3:0] ph;
	logic [3:0] n;

	initial begin
		busy          = 1'b0;
		got           = 1'b0;
		frame         = 14'h0000;
		rx_char_valid = 1'b0;
		rx_char_data  = 9'h000;
	end

	// sample mid-bit, frame[0] is the start bit
	always @(posedge clk) begin
		got <= busy && en && (ph == 4'h7) && (n == nbits - 4'h1);
		if (!busy) begin
			if (en && !line) begin
				busy <= 1'b1;
				ph   <= 4'h0;
				n    <= 4'h0;
			end
		end else if (!en) begin
			// released line: drop the cut frame
			busy <= 1'b0;
		end else begin
			ph <= ph + 4'h1;
			if (ph == 4'h7) begin
				frame[n] <= line;
				n        <= n + 4'h1;
				if (n == nbits - 4'h1) begin
					busy <= 1'b0;
				end
			end
		end
	end

	task automatic send(input logic [8:0] d);
		@(posedge clk);
		rx_char_valid <= 1'b1;
		rx_char_data  <= d;
		@(posedge clk);
		rx_char_valid <= 1'b0;
		rx_char_data  <= ~d;
		#1;
	endtask : send
endmodule : usc_remote_model

`default_nettype wire

// *** verification/usc_top_monitor.sv ***
/*
 * Port checker for the serial port status and control block, bound to usc_top.
 * Assumes register reads and received characters never share a clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
`include "usc_defines.svh"

module usc_top_monitor (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic [`USC_ADDR_W-1:0] reg_addr,
	input wire logic [15:0]            reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [15:0]            reg_rdata,
	input wire logic                   rx_char_valid,
	input wire logic [`USC_DATA_W-1:0] rx_char_data,
	input wire logic                   serial_tx_pin_out,
	input wire logic                   serial_tx_pin_oe,
	input wire logic                   tx_irq,
	input wire logic                   rx_irq
);
	logic [15:0] sta_reg;
	logic [15:0] mode_reg;
	logic [2:0]  lvl_reg;
	logic [7:0]  low_cnt_reg;
	logic [2:0]  ir_cnt_reg;
	logic [1:0]  rxm;
	logic        accept;

	assign rxm    = sta_reg[`USC_STA_RXM_HI:`USC_STA_RXM_LO];
	assign accept = rx_char_valid && lvl_reg != `USC_RX_FULL && !(sta_reg[`USC_STA_ADDR_DETECT_EN]
		&& mode_reg[`USC_MODE_PDS_HI:`USC_MODE_PDS_LO] == 2'b11 && !rx_char_data[8]);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sta_reg  <= 16'h0000;
			mode_reg <= 16'h0000;
		end else if (reg_wr && reg_addr == `USC_OFS_STA) begin
			sta_reg <= reg_wdata;
		end else if (reg_wr && reg_addr == `USC_OFS_MODE) begin
			mode_reg <= reg_wdata;
		end
	end

	// receive buffer level as software sees it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lvl_reg <= 3'h0;
		end else if (accept) begin
			lvl_reg <= lvl_reg + 3'h1;
		end else if (reg_rd && reg_addr == `USC_OFS_RXD && lvl_reg != 3'h0) begin
			lvl_reg <= lvl_reg - 3'h1;
		end
	end

	// length of a low run on the plain line
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_cnt_reg <= 8'h00;
		end else if (serial_tx_pin_oe && !mode_reg[`USC_MODE_INFRARED_ENCODER_EN] && !serial_tx_pin_out) begin
			low_cnt_reg <= low_cnt_reg + {7'h00, low_cnt_reg != 8'hFF};
		end else begin
			low_cnt_reg <= 8'h00;
		end
	end

	// cycles the encoded line leaves its idle level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ir_cnt_reg <= 3'h0;
		end else if (serial_tx_pin_oe && mode_reg[`USC_MODE_INFRARED_ENCODER_EN]
			&& serial_tx_pin_out != sta_reg[`USC_STA_INV]) begin
			ir_cnt_reg <= ir_cnt_reg + {2'h0, ir_cnt_reg != 3'h7};
		end else begin
			ir_cnt_reg <= 3'h0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_rx_each;
		accept && !rxm[1] |=> rx_irq;
	endproperty
	a_rx_each: assert property (p_rx_each) else $error("rx irq missing per char");
	property p_rx_3q;
		accept && rxm == 2'b10 && lvl_reg == 3'h2 |=> rx_irq;
	endproperty
	a_rx_3q: assert property (p_rx_3q) else $error("rx irq missing at three");
	property p_rx_full;
		accept && rxm == 2'b11 && lvl_reg == 3'h3 |=> rx_irq;
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("rx irq missing at four");
	property p_rx_quiet;
		rx_irq |-> $past(accept && (!rxm[1] || lvl_reg == {1'b0, rxm}));
	endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("rx irq without cause");
	property p_ro_flags;
		$past(reg_rd && reg_addr == `USC_OFS_STA) |-> !(reg_rdata[`USC_STA_TXBF] && reg_rdata[`USC_STA_DONE]);
	endproperty
	a_ro_flags: assert property (p_ro_flags) else $error("full and done together");
	property p_brk_len;
		low_cnt_reg <= 8'hD0;
	endproperty
	a_brk_len: assert property (p_brk_len) else $error("low run too long");
	property p_ir_idle;
		ir_cnt_reg <= 3'h3;
	endproperty
	a_ir_idle: assert property (p_ir_idle) else $error("encoded idle level wrong");
	property p_oe_on;
		reg_wr && reg_addr == `USC_OFS_STA && reg_wdata[`USC_STA_TXEN] |-> ##[1:2] serial_tx_pin_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin not taken");
	property p_oe_off;
		reg_wr && reg_addr == `USC_OFS_STA && !reg_wdata[`USC_STA_TXEN] |-> ##[1:2] !serial_tx_pin_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin not released");
endmodule : usc_top_monitor

bind usc_top usc_top_monitor i_usc_top_monitor (
	.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid),
	.rx_char_data(rx_char_data), .serial_tx_pin_out(serial_tx_pin_out),
	.serial_tx_pin_oe(serial_tx_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

`default_nettype wire

// *** verilog/usc_fifo.sv ***
/*
 * Small synchronous FIFO, width and depth from its own W and D parameters.
 * Assumes one clock, asynchronous active-high reset; flush empties it.
 */
`timescale 1ns/10ps
`default_nettype none

module usc_fifo #(
	parameter int W = 9,
	parameter int D = 4
) (
	input  wire logic   clk,
	input  wire logic   rst,
	usc_fifo_if.buffer  f
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D+1);

	logic [W-1:0]  mem [D];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [CW-1:0] level_reg;
	logic          push;
	logic          pop;

	assign f.wr_ready = (level_reg != CW'(D));
	assign f.rd_valid = (level_reg != '0);
	assign f.rd_data  = mem[rd_ptr_reg];
	assign f.level    = level_reg;
	assign push       = f.wr_valid && f.wr_ready && !f.flush;
	assign pop        = f.rd_ready && f.rd_valid && !f.flush;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= f.wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else if (f.flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(D-1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(D-1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
			end
			if (push && !pop) begin
				level_reg <= CW'(level_reg + 1'b1);
			end else if (pop && !push) begin
				level_reg <= CW'(level_reg - 1'b1);
			end
		end
	end
endmodule : usc_fifo

`default_nettype wire

// *** verilog/usc_top.sv ***
/*
 * Serial port status and control: register port, 4-deep transmit and receive
 * buffers, transmit shifter with break and infrared encoding, interrupt events.
 * Assumes received characters arrive already assembled from the receive shift
 * register, one per valid pulse, synchronous to clk.
 */
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

`include "usc_defines.svh"

module usc_top (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [`USC_ADDR_W-1:0]  reg_addr,
	input  wire logic [15:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output var  logic [15:0]             reg_rdata,
	input  wire logic                    rx_char_valid,
	input  wire logic [`USC_DATA_W-1:0]  rx_char_data,
	output var  logic                    serial_tx_pin_out,
	output var  logic                    serial_tx_pin_oe,
	output var  logic                    tx_irq,
	output var  logic                    rx_irq
);
	localparam int TICK_CYC = `USC_TICK_CYC;
	localparam int DIV_W    = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

	// control and mode bits
	usc_pkg::usc_tx_irq_mode_t     tx_irq_mode;
	usc_pkg::usc_parity_data_sel_t parity_data_sel;
	logic [15:0] sta_reg;
	logic [15:0] mode_reg;
	logic        send_break_req;
	logic        tx_enable_bit;
	logic        tx_encoded_idle_invert;
	logic        infrared_encoder_en;
	logic        addr_detect_en;
	logic [1:0]  rx_irq_mode;
	logic        nine_bit;

	// transmit path
	usc_pkg::usc_tx_state_t tx_state_reg;
	logic [13:0]       frame_reg;
	logic [3:0]        bits_left_reg;
	logic [3:0]        ovs_reg;
	logic [DIV_W-1:0]  div_reg;
	logic              tick;
	logic              bit_end;
	logic              frame_end;
	logic              tx_load;
	logic              brk_active_reg;
	logic              brk_done;
	logic              tx_buf_full_flag;
	logic              tx_all_done_flag;
	logic              tx_push;
	logic              pin_level;
	logic [8:0]        tx_char;
	logic              even_par;

	// receive path
	logic              rx_accept;
	logic              rx_pop;
	logic [2:0]        rx_level_after;

	usc_fifo_if #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) txq ();
	usc_fifo_if #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) rxq ();

	usc_fifo #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) u_tx_fifo (
		.clk (clk),
		.rst (rst),
		.f   (txq)
	);

	usc_fifo #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) u_rx_fifo (
		.clk (clk),
		.rst (rst),
		.f   (rxq)
	);

	assign tx_irq_mode            = usc_pkg::usc_tx_irq_mode_t'({sta_reg[`USC_STA_TXM1], sta_reg[`USC_STA_TXM0]});
	assign tx_encoded_idle_invert = sta_reg[`USC_STA_INV];
	assign send_break_req         = sta_reg[`USC_STA_BRK];
	assign tx_enable_bit          = sta_reg[`USC_STA_TXEN];
	assign rx_irq_mode            = sta_reg[`USC_STA_RXM_HI:`USC_STA_RXM_LO];
	assign addr_detect_en         = sta_reg[`USC_STA_ADDR_DETECT_EN];
	assign infrared_encoder_en    = mode_reg[`USC_MODE_INFRARED_ENCODER_EN];
	assign parity_data_sel        = usc_pkg::usc_parity_data_sel_t'(mode_reg[`USC_MODE_PDS_HI:`USC_MODE_PDS_LO]);
	assign nine_bit               = (parity_data_sel == usc_pkg::USC_PDS_9N);

	// status flags
	assign tx_buf_full_flag = !txq.wr_ready;
	assign tx_all_done_flag = !txq.rd_valid && (tx_state_reg == usc_pkg::USC_TX_IDLE);

	// baud divider and oversample counter
	assign tick      = (div_reg == DIV_W'(TICK_CYC - 1));
	assign bit_end   = tick && (ovs_reg == `USC_OVS_LAST);
	assign frame_end = bit_end && (bits_left_reg == 4'h1) && (tx_state_reg == usc_pkg::USC_TX_SHIFT);
	assign brk_done  = frame_end && brk_active_reg;

	// transmit buffer hooks
	assign tx_push       = reg_wr && (reg_addr == `USC_OFS_TXD) && tx_enable_bit;
	assign txq.wr_valid  = tx_push;
	assign txq.wr_data   = reg_wdata[8:0];
	assign txq.flush     = !tx_enable_bit;
	assign tx_load       = tx_enable_bit && (tx_state_reg == usc_pkg::USC_TX_IDLE) && !send_break_req && txq.rd_valid;
	assign txq.rd_ready  = tx_load;
	assign tx_char       = txq.rd_data;
	assign even_par      = ^tx_char[7:0];

	// receive buffer hooks
	assign rx_accept     = rx_char_valid && !(addr_detect_en && nine_bit && !rx_char_data[8]);
	assign rxq.wr_valid  = rx_accept;
	assign rxq.wr_data   = nine_bit ? rx_char_data : {1'b0, rx_char_data[7:0]};
	assign rxq.flush     = 1'b0;
	assign rx_pop        = reg_rd && (reg_addr == `USC_OFS_RXD);
	assign rxq.rd_ready  = rx_pop;
	assign rx_level_after = (rx_pop && rxq.rd_valid) ? rxq.level : 3'(rxq.level + 1'b1);

	// status and control register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sta_reg <= `USC_STA_RESET;
		end else if (reg_wr && (reg_addr == `USC_OFS_STA)) begin
			sta_reg[`USC_STA_TXM1]                    <= reg_wdata[`USC_STA_TXM1];
			sta_reg[`USC_STA_INV]                     <= reg_wdata[`USC_STA_INV];
			sta_reg[`USC_STA_TXM0]                    <= reg_wdata[`USC_STA_TXM0];
			sta_reg[`USC_STA_BRK]                     <= reg_wdata[`USC_STA_BRK] || (send_break_req && !brk_done);
			sta_reg[`USC_STA_TXEN]                    <= reg_wdata[`USC_STA_TXEN];
			sta_reg[`USC_STA_RXM_HI:`USC_STA_RXM_LO] <= reg_wdata[`USC_STA_RXM_HI:`USC_STA_RXM_LO];
			sta_reg[`USC_STA_ADDR_DETECT_EN]                   <= reg_wdata[`USC_STA_ADDR_DETECT_EN];
		end else if (brk_done || !tx_enable_bit) begin
			sta_reg[`USC_STA_BRK] <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= `USC_MODE_RESET;
		end else if (reg_wr && (reg_addr == `USC_OFS_MODE)) begin
			mode_reg <= reg_wdata;
		end
	end

	// read port, data valid in the following cycle only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`USC_OFS_STA: begin
					reg_rdata <= {sta_reg[15:10], tx_buf_full_flag, tx_all_done_flag, sta_reg[7:5], 5'h00};
				end
				`USC_OFS_MODE: begin
					reg_rdata <= mode_reg;
				end
				`USC_OFS_RXD: begin
					reg_rdata <= rxq.rd_valid ? {7'h00, rxq.rd_data} : 16'h0000;
				end
				default: begin
					reg_rdata <= 16'h0000;
				end
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// baud divider
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
			ovs_reg <= 4'h0;
		end else if (tx_state_reg == usc_pkg::USC_TX_IDLE) begin
			div_reg <= '0;
			ovs_reg <= 4'h0;
		end else if (tick) begin
			div_reg <= '0;
			ovs_reg <= 4'(ovs_reg + 1'b1);
		end else begin
			div_reg <= DIV_W'(div_reg + 1'b1);
		end
	end

	// transmit shifter, frames are sent lsb first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_state_reg   <= usc_pkg::USC_TX_IDLE;
			frame_reg      <= 14'h3FFF;
			bits_left_reg  <= 4'h0;
			brk_active_reg <= 1'b0;
		end else if (!tx_enable_bit) begin
			tx_state_reg   <= usc_pkg::USC_TX_IDLE;
			frame_reg      <= 14'h3FFF;
			bits_left_reg  <= 4'h0;
			brk_active_reg <= 1'b0;
		end else begin
			case (tx_state_reg)
				usc_pkg::USC_TX_IDLE: begin
					if (send_break_req) begin
						frame_reg      <= {1'b1, 12'h000, 1'b0};
						bits_left_reg  <= `USC_BRK_BITS;
						brk_active_reg <= 1'b1;
						tx_state_reg   <= usc_pkg::USC_TX_SHIFT;
					end else if (tx_load) begin
						case (parity_data_sel)
							usc_pkg::USC_PDS_9N: begin
								frame_reg     <= {4'hF, tx_char, 1'b0};
								bits_left_reg <= `USC_BITS_LONG;
							end
							usc_pkg::USC_PDS_8E: begin
								frame_reg     <= {4'hF, even_par, tx_char[7:0], 1'b0};
								bits_left_reg <= `USC_BITS_LONG;
							end
							usc_pkg::USC_PDS_8O: begin
								frame_reg     <= {4'hF, !even_par, tx_char[7:0], 1'b0};
								bits_left_reg <= `USC_BITS_LONG;
							end
							default: begin
								frame_reg     <= {5'h1F, tx_char[7:0], 1'b0};
								bits_left_reg <= `USC_BITS_8N;
							end
						endcase
						tx_state_reg <= usc_pkg::USC_TX_SHIFT;
					end
				end
				usc_pkg::USC_TX_SHIFT: begin
					if (bit_end) begin
						frame_reg     <= {1'b1, frame_reg[13:1]};
						bits_left_reg <= 4'(bits_left_reg - 1'b1);
						if (bits_left_reg == 4'h1) begin
							tx_state_reg   <= usc_pkg::USC_TX_IDLE;
							brk_active_reg <= 1'b0;
						end
					end
				end
				default: begin
					tx_state_reg <= usc_pkg::USC_TX_IDLE;
				end
			endcase
		end
	end

	// pin level: plain marks idle high, encoder pulses low bits early in the bit
	always_comb begin
		pin_level = frame_reg[0];
		if (infrared_encoder_en) begin
			pin_level = tx_encoded_idle_invert;
			if ((tx_state_reg == usc_pkg::USC_TX_SHIFT) && !frame_reg[0] && (ovs_reg < `USC_IR_PULSE)) begin
				pin_level = !tx_encoded_idle_invert;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_tx_pin_out <= 1'b1;
			serial_tx_pin_oe  <= 1'b0;
		end else begin
			serial_tx_pin_out <= pin_level;
			serial_tx_pin_oe  <= tx_enable_bit;
		end
	end

	// transmit interrupt event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_irq <= 1'b0;
		end else begin
			case (tx_irq_mode)
				usc_pkg::USC_TXI_EACH: begin
					tx_irq <= tx_load;
				end
				usc_pkg::USC_TXI_EMPTIED: begin
					tx_irq <= tx_load && (txq.level == 3'h1) && !tx_push;
				end
				usc_pkg::USC_TXI_ALL_DONE: begin
					tx_irq <= frame_end && !brk_active_reg && !txq.rd_valid && !tx_push;
				end
				default: begin
					tx_irq <= 1'b0;
				end
			endcase
		end
	end

	// receive interrupt event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_irq <= 1'b0;
		end else if (rx_accept && rxq.wr_ready) begin
			case (rx_irq_mode)
				2'h3: begin
					rx_irq <= (rx_level_after == `USC_RX_FULL);
				end
				2'h2: begin
					rx_irq <= (rx_level_after == `USC_RX_3Q);
				end
				default: begin
					rx_irq <= 1'b1;
				end
			endcase
		end else begin
			rx_irq <= 1'b0;
		end
	end
endmodule : usc_top

`default_nettype wire
